// ==== pkg/exec_pkg.sv ====
// Purpose: Shared constants and types for the bit, flag and shift executor
// Assumes: APB with 8-bit byte addresses and 32-bit data
// Notes:   Command word fields and opcode values are used by software and bench
package exec_pkg;

    // ==========================================================
    // Register map
    localparam logic [7:0] CMD_ADDR = 8'h00;
    localparam logic [7:0] STATUS_ADDR = 8'h04;
    localparam logic [7:0] SP_ADDR = 8'h08;
    localparam logic [7:0] REGFILE_BASE = 8'h80;
    localparam int REG_IDX_LSB = 2;
    localparam int REG_IDX_MSB = 6;
    localparam int BUSY_BIT = 8;
    localparam logic [15:0] SP_RESET = 16'h0000;
    localparam logic [7:0] FLAGS_RESET = 8'h00;

    // ==========================================================
    // Command word fields
    localparam int OP_LSB = 0;
    localparam int OP_MSB = 5;
    localparam int RSEL_LSB = 8;
    localparam int RSEL_MSB = 12;
    localparam int BSEL_LSB = 16;
    localparam int BSEL_MSB = 18;
    localparam int IO_LSB = 24;
    localparam int IO_MSB = 28;

    // ==========================================================
    // Status flag positions
    localparam logic [2:0] FLAG_C = 3'h0;
    localparam logic [2:0] FLAG_Z = 3'h1;
    localparam logic [2:0] FLAG_N = 3'h2;
    localparam logic [2:0] FLAG_V = 3'h3;
    localparam logic [2:0] FLAG_S = 3'h4;
    localparam logic [2:0] FLAG_H = 3'h5;
    localparam logic [2:0] FLAG_T = 3'h6;
    localparam logic [2:0] FLAG_I = 3'h7;

    // ==========================================================
    // Opcodes; named flag ops are 0x20 + index (set) or 0x28 + index (clear)
    localparam logic [5:0] IDLE_OP = 6'h00;
    localparam logic [5:0] POP_OP = 6'h01;
    localparam logic [5:0] IO_BIT_SET_OP = 6'h02;
    localparam logic [5:0] IO_BIT_CLEAR_OP = 6'h03;
    localparam logic [5:0] LOGIC_SHIFT_LEFT_OP = 6'h04;
    localparam logic [5:0] LOGIC_SHIFT_RIGHT_OP = 6'h05;
    localparam logic [5:0] ROTATE_LEFT_CARRY_OP = 6'h06;
    localparam logic [5:0] ROTATE_RIGHT_CARRY_OP = 6'h07;
    localparam logic [5:0] ARITH_SHIFT_RIGHT_OP = 6'h08;
    localparam logic [5:0] NIBBLE_SWAP_OP = 6'h09;
    localparam logic [5:0] FLAG_SET_INDEXED_OP = 6'h0a;
    localparam logic [5:0] FLAG_CLEAR_INDEXED_OP = 6'h0b;
    localparam logic [5:0] BIT_TO_TRANSFER_OP = 6'h0c;
    localparam logic [5:0] TRANSFER_TO_BIT_OP = 6'h0d;
    localparam logic [5:0] SLEEP_OP = 6'h0e;
    localparam logic [5:0] WATCHDOG_RESTART_OP = 6'h0f;
    localparam logic [5:0] BREAK_OP = 6'h10;
    localparam int NAMED_BIT = 5;
    localparam int NAMED_CLEAR_BIT = 3;
    localparam logic [5:0] CARRY_SET_OP = 6'h20;
    localparam logic [5:0] CARRY_CLEAR_OP = 6'h28;
    localparam logic [5:0] ZERO_SET_OP = 6'h21;
    localparam logic [5:0] ZERO_CLEAR_OP = 6'h29;
    localparam logic [5:0] NEGATIVE_SET_OP = 6'h22;
    localparam logic [5:0] NEGATIVE_CLEAR_OP = 6'h2a;
    localparam logic [5:0] OVERFLOW_SET_OP = 6'h23;
    localparam logic [5:0] OVERFLOW_CLEAR_OP = 6'h2b;
    localparam logic [5:0] SIGNED_SET_OP = 6'h24;
    localparam logic [5:0] SIGNED_CLEAR_OP = 6'h2c;
    localparam logic [5:0] HALF_CARRY_SET_OP = 6'h25;
    localparam logic [5:0] HALF_CARRY_CLEAR_OP = 6'h2d;
    localparam logic [5:0] TRANSFER_SET_OP = 6'h26;
    localparam logic [5:0] TRANSFER_CLEAR_OP = 6'h2e;
    localparam logic [5:0] IRQ_ENABLE_OP = 6'h27;
    localparam logic [5:0] IRQ_DISABLE_OP = 6'h2f;

    // ==========================================================
    // Types
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_FIRST = 2'b01,
        ST_SECOND = 2'b11
    } exec_state_e;

    typedef enum logic [2:0] {
        SH_LEFT_ZERO = 3'h0,
        SH_RIGHT_ZERO = 3'h1,
        SH_LEFT_CARRY = 3'h2,
        SH_RIGHT_CARRY = 3'h3,
        SH_RIGHT_SIGN = 3'h4,
        SH_SWAP = 3'h5
    } shift_sel_e;

endpackage : exec_pkg

// ==== pkg/shift_if.sv ====
// Purpose: Carries operand and result between executor and shifter
// Assumes: Purely combinational unit on the far side
// Notes:   None
`timescale 1ns/1ns
interface shift_if;
    import exec_pkg::*;
    shift_sel_e sel;
    logic [7:0] operand;
    logic carry_in;
    logic [7:0] result;
    logic carry_out;
    modport user (output sel, output operand, output carry_in, input result, input carry_out);
    modport unit (input sel, input operand, input carry_in, output result, output carry_out);
endinterface : shift_if

// ==== rtl/shift_unit.sv ====
// Purpose: Shift, rotate and nibble swap of one working register
// Assumes: Caller latches the result
// Notes:   Carry out is meaningless for the nibble swap
`timescale 1ns/1ns
module shift_unit
    import exec_pkg::*;
(
    shift_if.unit sh
);

    // ==========================================================
    // Datapath
    always_comb
    begin
        sh.result = sh.operand;
        sh.carry_out = sh.carry_in;
        unique case (sh.sel)
            SH_LEFT_ZERO:
            begin
                sh.result = {sh.operand[6:0], 1'b0};
                sh.carry_out = sh.operand[7];
            end
            SH_RIGHT_ZERO:
            begin
                sh.result = {1'b0, sh.operand[7:1]};
                sh.carry_out = sh.operand[0];
            end
            SH_LEFT_CARRY:
            begin
                sh.result = {sh.operand[6:0], sh.carry_in};
                sh.carry_out = sh.operand[7];
            end
            SH_RIGHT_CARRY:
            begin
                sh.result = {sh.carry_in, sh.operand[7:1]};
                sh.carry_out = sh.operand[0];
            end
            SH_RIGHT_SIGN:
            begin
                sh.result = {sh.operand[7], sh.operand[7:1]};
                sh.carry_out = sh.operand[0];
            end
            SH_SWAP:
            begin
                sh.result = {sh.operand[3:0], sh.operand[7:4]};
            end
            default:
            begin
                sh.result = sh.operand;
            end
        endcase
    end

endmodule : shift_unit

// ==== rtl/bit_flag_mcu_instr_exec.sv ====
// Purpose: Executes stack pop, I/O bit, shift, flag and control instructions
// Assumes: Stack and I/O space answer mem_rdata in the same cycle as mem_rd
// Notes:   Software issues one instruction per write to the command register
`timescale 1ns/1ns
module bit_flag_mcu_instr_exec
    import exec_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic mem_rd,
    output logic mem_wr,
    output logic mem_io,
    output logic [15:0] mem_addr,
    output logic [7:0] mem_wdata,
    input wire logic [7:0] mem_rdata,
    output logic sleep_req,
    output logic wdt_restart,
    output logic brk_req
);

    // ==========================================================
    // State
    exec_state_e state;
    logic [7:0] regs [32];
    logic [7:0] status_flags_reg;
    logic [15:0] sp;
    logic [5:0] op_q;
    logic [4:0] rsel_q;
    logic [2:0] bsel_q;
    logic [4:0] io_q;

    shift_if sh ();

    shift_unit u_shift (
        .sh(sh)
    );

    // ==========================================================
    // Bus decode
    wire busy = (state != ST_IDLE);
    wire aligned = (paddr[1:0] == 2'b00);
    wire hit_cmd = aligned && (paddr == CMD_ADDR);
    wire hit_status = aligned && (paddr == STATUS_ADDR);
    wire hit_sp = aligned && (paddr == SP_ADDR);
    wire hit_rf = aligned && (paddr >= REGFILE_BASE);
    wire mapped = hit_cmd || hit_status || hit_sp || hit_rf;
    // Writes while an instruction runs are refused so no field changes mid-flight
    wire setup_err = !mapped || (pwrite && busy);
    wire setup = psel && !penable;
    wire access_ok = psel && penable && pready && !pslverr;
    wire wr_ok = access_ok && pwrite;
    wire [4:0] rf_idx = paddr[REG_IDX_MSB:REG_IDX_LSB];

    logic [31:0] read_mux;
    always_comb
    begin
        read_mux = 32'h0000_0000;
        if (hit_status)
            read_mux = {23'h000000, busy, status_flags_reg};
        else if (hit_sp)
            read_mux = {16'h0000, sp};
        else if (hit_rf)
            read_mux = {24'h000000, regs[rf_idx]};
    end

    // ==========================================================
    // Command fields
    wire launch = wr_ok && hit_cmd;
    wire [5:0] cmd_op = pwdata[OP_MSB:OP_LSB];
    wire cmd_pop = (cmd_op == POP_OP);
    wire cmd_io = (cmd_op == IO_BIT_SET_OP) || (cmd_op == IO_BIT_CLEAR_OP);
    wire [15:0] pop_addr = sp + 16'h0001;
    wire [4:0] cmd_io_addr = pwdata[IO_MSB:IO_LSB];

    // ==========================================================
    // Execute decode
    wire [7:0] operand = regs[rsel_q];
    wire [7:0] bit_mask = 8'h01 << bsel_q;
    wire is_shift = (op_q >= LOGIC_SHIFT_LEFT_OP) && (op_q <= ARITH_SHIFT_RIGHT_OP);
    wire is_swap = (op_q == NIBBLE_SWAP_OP);
    wire is_t_load = (op_q == TRANSFER_TO_BIT_OP);
    wire is_t_store = (op_q == BIT_TO_TRANSFER_OP);
    wire is_named = op_q[NAMED_BIT];
    wire is_idx_flag = (op_q == FLAG_SET_INDEXED_OP) || (op_q == FLAG_CLEAR_INDEXED_OP);
    wire is_pop = (op_q == POP_OP);
    wire is_io_set = (op_q == IO_BIT_SET_OP);
    wire two_cycle = is_pop || is_io_set || (op_q == IO_BIT_CLEAR_OP);
    wire [2:0] flag_idx = is_named ? op_q[2:0] : bsel_q;
    wire flag_val = is_named ? !op_q[NAMED_CLEAR_BIT] : (op_q == FLAG_SET_INDEXED_OP);
    wire [7:0] flag_mask = 8'h01 << flag_idx;

    assign sh.operand = operand;
    assign sh.carry_in = status_flags_reg[FLAG_C];
    assign sh.sel = (op_q == LOGIC_SHIFT_LEFT_OP) ? SH_LEFT_ZERO :
                    (op_q == LOGIC_SHIFT_RIGHT_OP) ? SH_RIGHT_ZERO :
                    (op_q == ROTATE_LEFT_CARRY_OP) ? SH_LEFT_CARRY :
                    (op_q == ROTATE_RIGHT_CARRY_OP) ? SH_RIGHT_CARRY :
                    (op_q == ARITH_SHIFT_RIGHT_OP) ? SH_RIGHT_SIGN : SH_SWAP;

    wire res_n = sh.result[7];
    wire res_c = sh.carry_out;
    wire [7:0] t_load_val = (operand & ~bit_mask) | ({8{status_flags_reg[FLAG_T]}} & bit_mask);
    wire [7:0] io_mod = is_io_set ? (mem_rdata | bit_mask) : (mem_rdata & ~bit_mask);

    // Only the flags an instruction names may move; everything else keeps its value
    logic [7:0] next_flags;
    always_comb
    begin
        next_flags = status_flags_reg;
        if (is_shift)
        begin
            next_flags[FLAG_C] = res_c;
            next_flags[FLAG_Z] = (sh.result == 8'h00);
            next_flags[FLAG_N] = res_n;
            next_flags[FLAG_V] = res_n ^ res_c;
        end
        else if (is_t_store)
            next_flags[FLAG_T] = operand[bsel_q];
        else if (is_named || is_idx_flag)
            next_flags = flag_val ? (status_flags_reg | flag_mask)
                                  : (status_flags_reg & ~flag_mask);
    end

    wire rf_we = is_shift || is_swap || is_t_load;
    wire [7:0] rf_wval = is_t_load ? t_load_val : sh.result;

    // ==========================================================
    // Bus answer: one wait-free access phase after each setup
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else
        begin
            pready <= setup;
            pslverr <= setup && setup_err;
            prdata <= (setup && !setup_err && !pwrite) ? read_mux : 32'h0000_0000;
        end
    end

    // ==========================================================
    // Sequencer
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state <= ST_IDLE;
            op_q <= IDLE_OP;
            rsel_q <= 5'h00;
            bsel_q <= 3'h0;
            io_q <= 5'h00;
        end
        else
        begin
            unique case (state)
                ST_IDLE:
                begin
                    if (launch)
                    begin
                        state <= ST_FIRST;
                        op_q <= cmd_op;
                        rsel_q <= pwdata[RSEL_MSB:RSEL_LSB];
                        bsel_q <= pwdata[BSEL_MSB:BSEL_LSB];
                        io_q <= cmd_io_addr;
                    end
                end
                ST_FIRST:
                begin
                    state <= two_cycle ? ST_SECOND : ST_IDLE;
                end
                ST_SECOND:
                begin
                    state <= ST_IDLE;
                end
                default:
                begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // Architectural state and register window
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < 32; i++)
                regs[i] <= 8'h00;
            status_flags_reg <= FLAGS_RESET;
            sp <= SP_RESET;
        end
        else if (state == ST_FIRST)
        begin
            status_flags_reg <= next_flags;
            if (is_pop)
            begin
                regs[rsel_q] <= mem_rdata;
                sp <= pop_addr;
            end
            else if (rf_we)
                regs[rsel_q] <= rf_wval;
        end
        else if (wr_ok)
        begin
            if (hit_status)
                status_flags_reg <= pwdata[7:0];
            if (hit_sp)
                sp <= pwdata[15:0];
            if (hit_rf)
                regs[rf_idx] <= pwdata[7:0];
        end
    end

    // ==========================================================
    // Stack and I/O space port
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mem_rd <= 1'b0;
            mem_wr <= 1'b0;
            mem_io <= 1'b0;
            mem_addr <= 16'h0000;
            mem_wdata <= 8'h00;
        end
        else if (launch && (cmd_pop || cmd_io))
        begin
            mem_rd <= 1'b1;
            mem_io <= cmd_io;
            mem_addr <= cmd_pop ? pop_addr : {11'h000, cmd_io_addr};
        end
        else if (state == ST_FIRST && two_cycle && !is_pop)
        begin
            mem_rd <= 1'b0;
            mem_wr <= 1'b1;
            mem_wdata <= io_mod;
            mem_addr <= {11'h000, io_q};
        end
        else
        begin
            mem_rd <= 1'b0;
            mem_wr <= 1'b0;
        end
    end

    // ==========================================================
    // Control strobes; the sleep and watchdog logic acts on them
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sleep_req <= 1'b0;
            wdt_restart <= 1'b0;
            brk_req <= 1'b0;
        end
        else
        begin
            sleep_req <= launch && (cmd_op == SLEEP_OP);
            wdt_restart <= launch && (cmd_op == WATCHDOG_RESTART_OP);
            brk_req <= launch && (cmd_op == BREAK_OP);
        end
    end

endmodule : bit_flag_mcu_instr_exec

// ==== dv/mem_model.sv ====
// Purpose: Stack memory and I/O space seen by the executor
// Assumes: Read data is due in the cycle of the read strobe
// Notes:   Contents preload to their address xor 8'h5c for stack and 8'h3c for I/O
`timescale 1ns/1ns
module mem_model
(
    input wire logic pclk,
    input wire logic mem_rd,
    input wire logic mem_wr,
    input wire logic mem_io,
    input wire logic [15:0] mem_addr,
    input wire logic [7:0] mem_wdata,
    output logic [7:0] mem_rdata
);
    // ==========================================================
    // Storage
    logic [7:0] stk [256];
    logic [7:0] io [32];
    logic [7:0] last = 8'h00;
    logic [7:0] sel;
    initial
    begin
        for (int i = 0; i < 256; i++)
            stk[i] = 8'(i) ^ 8'h5c;
        for (int i = 0; i < 32; i++)
            io[i] = 8'(i) ^ 8'h3c;
    end
    assign sel = mem_io ? io[mem_addr[4:0]] : stk[mem_addr[7:0]];
    // Not held while idle, so a late sample cannot pass by luck
    assign mem_rdata = mem_rd ? sel : ~last;
    always @(posedge pclk)
    begin
        if (mem_rd)
            last <= sel;
        if (mem_wr && mem_io)
            io[mem_addr[4:0]] <= mem_wdata;
    end
endmodule : mem_model

// ==== dv/exec_checker.sv ====
// Purpose: Port checks for the executor
// Assumes: One clock, reset active low
// Notes:   Command fields are taken from the accepting edge by $past
`timescale 1ns/1ns
module exec_checker
    import exec_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic mem_rd,
    input wire logic mem_wr,
    input wire logic mem_io,
    input wire logic [15:0] mem_addr,
    input wire logic [7:0] mem_wdata,
    input wire logic [7:0] mem_rdata,
    input wire logic sleep_req,
    input wire logic wdt_restart,
    input wire logic brk_req
);
    logic take;
    logic [5:0] op;
    logic [7:0] bmask;
    assign take = psel && penable && pready && pwrite && !pslverr && paddr == CMD_ADDR;
    assign op = pwdata[OP_MSB:OP_LSB];
    assign bmask = 8'h01 << pwdata[BSEL_MSB:BSEL_LSB];
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // ==========================================================
    // Steps of an I/O read-modify-write
    sequence io_rd_s;
        mem_rd && mem_io && !mem_wr && mem_addr == {11'h000, $past(pwdata[IO_MSB:IO_LSB])};
    endsequence
    sequence io_wr_s;
        mem_wr && mem_io && !mem_rd && mem_addr == {11'h000, $past(pwdata[IO_MSB:IO_LSB], 2)};
    endsequence
    property pulse_p(logic [5:0] code, logic s);
        take && op == code |=> s ##1 !s;
    endproperty
    // ==========================================================
    // Assertions
    ready_next_a: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    ready_once_a: assert property (psel && penable |=> !pready)
        else $error("ready held too long");
    bad_addr_a: assert property (psel && !penable && paddr[1:0] != 2'b00 |=> pslverr)
        else $error("unaligned access not refused");
    rdata_zero_a: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside access");
    pop_read_a: assert property (take && op == POP_OP |=> mem_rd && !mem_io ##1 !mem_rd)
        else $error("pop read wrong");
    io_set_a: assert property (take && op == IO_BIT_SET_OP |=> io_rd_s ##1 io_wr_s
        ##0 mem_wdata == ($past(mem_rdata) | $past(bmask, 2)))
        else $error("io set wrong");
    io_clear_a: assert property (take && op == IO_BIT_CLEAR_OP |=> io_rd_s ##1 io_wr_s
        ##0 mem_wdata == ($past(mem_rdata) & ~$past(bmask, 2)))
        else $error("io clear wrong");
    sleep_pulse_a: assert property (pulse_p(SLEEP_OP, sleep_req))
        else $error("sleep pulse wrong");
    wdt_pulse_a: assert property (pulse_p(WATCHDOG_RESTART_OP, wdt_restart))
        else $error("restart pulse wrong");
    brk_pulse_a: assert property (pulse_p(BREAK_OP, brk_req))
        else $error("break pulse wrong");
endmodule : exec_checker
bind bit_flag_mcu_instr_exec exec_checker chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_io(mem_io),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .sleep_req(sleep_req), .wdt_restart(wdt_restart), .brk_req(brk_req));

// ==== dv/tb.sv ====
// Purpose: Directed APB test of the executor
// Assumes: Model bytes equal address xor a fixed pattern per space, 8'h5c for stack and 8'h3c for I/O
// Notes:   Transfers are spaced by one idle cycle
`timescale 1ns/1ns
module tb;
    import exec_pkg::*;
    localparam logic [7:0] ST = STATUS_ADDR;
    localparam logic [7:0] RF = REGFILE_BASE;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, e;
    logic [7:0] paddr = 8'h00, mem_wdata, mem_rdata, base, v, fl;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic pready, pslverr, mem_rd, mem_wr, mem_io, sleep_req, wdt_restart, brk_req;
    logic [15:0] mem_addr;
    logic [8:0] q;
    logic [5:0] op;
    int miscompares = 0, cmp_count = 0, n_slp = 0, n_wdt = 0, n_brk = 0, np = 0;
    logic [5:0] sops [6] = '{LOGIC_SHIFT_LEFT_OP, LOGIC_SHIFT_RIGHT_OP, ROTATE_LEFT_CARRY_OP,
        ROTATE_RIGHT_CARRY_OP, ARITH_SHIFT_RIGHT_OP, NIBBLE_SWAP_OP};
    logic [7:0] vals [3] = '{8'h80, 8'h01, 8'h6d};

    always #4 pclk = ~pclk;
    always @(posedge pclk)
    begin
        n_slp <= n_slp + int'(sleep_req === 1'b1);
        n_wdt <= n_wdt + int'(wdt_restart === 1'b1);
        n_brk <= n_brk + int'(brk_req === 1'b1);
    end
    bit_flag_mcu_instr_exec dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_io(mem_io),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
        .sleep_req(sleep_req), .wdt_restart(wdt_restart), .brk_req(brk_req));
    mem_model mem_u (.pclk(pclk), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_io(mem_io),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

    // ==========================================================
    // Access tasks
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : complete_run
    task automatic hang;
        miscompares++;
        complete_run();
    endtask : hang
    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        cmp_count++;
        if (g !== x)
        begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", nm, x, g);
        end
    endtask : chk
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d, input logic x);
        int n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
            hang();
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk("slave error", 32'(x), 32'(e));
    endtask : xfer
    task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] x);
        xfer(a, 1'b0, 32'h0, 1'b0);
        chk(nm, x, r);
    endtask : rd
    // Polls busy; a fixed wait would hide a wrong cycle count
    task automatic settle;
        int n = 0;
        do
        begin
            xfer(ST, 1'b0, 32'h0, 1'b0);
            n++;
        end
        while (r[BUSY_BIT] !== 1'b0 && n < 20);
        np = n;
        if (r[BUSY_BIT] !== 1'b0)
            hang();
    endtask : settle
    task automatic cmd(input logic [5:0] o, input logic [4:0] rs, input logic [2:0] b,
        input logic [4:0] p, input logic w);
        xfer(CMD_ADDR, 1'b1, 32'(o) | (32'(rs) << RSEL_LSB) | (32'(b) << BSEL_LSB)
            | (32'(p) << IO_LSB), 1'b0);
        if (w)
            settle();
    endtask : cmd
    function automatic logic [8:0] sh(input logic [5:0] o, input logic [7:0] x, input logic c);
        case (o)
            LOGIC_SHIFT_LEFT_OP: return {x, 1'b0};
            LOGIC_SHIFT_RIGHT_OP: return {x[0], 1'b0, x[7:1]};
            ROTATE_LEFT_CARRY_OP: return {x, c};
            ROTATE_RIGHT_CARRY_OP: return {x[0], c, x[7:1]};
            ARITH_SHIFT_RIGHT_OP: return {x[0], x[7], x[7:1]};
            default: return {c, x[3:0], x[7:4]};
        endcase
    endfunction : sh

    // ==========================================================
    // Tests
    initial
    begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd("flags", ST, 32'h0);
        rd("stack ptr", SP_ADDR, 32'h0);
        rd("reg 31", RF + 8'h7c, 32'h0);
        rd("command", CMD_ADDR, 32'h0);
        xfer(8'h05, 1'b1, 32'h0, 1'b1);
        xfer(8'h0c, 1'b0, 32'h0, 1'b1);
        $display("test reset done");
        for (int k = 0; k < 6; k++)
            for (int j = 0; j < 6; j++)
            begin
                v = vals[j / 2];
                base = 8'h30 | 8'(j % 2);
                q = sh(sops[k], v, base[0]);
                fl = k == 5 ? base : {base[7:4], q[7] ^ q[8], q[7], q[7:0] == 8'h00, q[8]};
                xfer(ST, 1'b1, 32'(base), 1'b0);
                xfer(RF + 8'h0c, 1'b1, 32'(v), 1'b0);
                cmd(sops[k], 5'd3, 3'd0, 5'd0, 1'b1);
                rd("shift result", RF + 8'h0c, 32'(q[7:0]));
                rd("shift flags", ST, 32'(fl));
                chk("shift polls", 32'h1, 32'(np));
            end
        $display("test shifts done");
        // Named forms get a wrong index field, so only their own bit may move
        for (int i = 0; i < 8; i++)
            for (int k = 0; k < 4; k++)
            begin
                op = k == 0 ? FLAG_SET_INDEXED_OP : k == 1 ? FLAG_CLEAR_INDEXED_OP
                    : k == 2 ? CARRY_SET_OP + 6'(i) : CARRY_CLEAR_OP + 6'(i);
                base = k % 2 ? 8'h5a | (8'h01 << i) : 8'h5a & ~(8'h01 << i);
                xfer(ST, 1'b1, 32'(base), 1'b0);
                cmd(op, 5'd0, k < 2 ? 3'(i) : 3'(7 - i), 5'd0, 1'b1);
                rd("flag op", ST, 32'(base ^ (8'h01 << i)));
                chk("flag polls", 32'h1, 32'(np));
            end
        $display("test flags done");
        for (int t = 1; t >= 0; t--)
        begin
            fl = t ? 8'h40 : 8'h00;
            xfer(ST, 1'b1, 32'(~fl & 8'h40), 1'b0);
            xfer(RF + 8'h1c, 1'b1, 32'h10, 1'b0);
            xfer(RF + 8'h20, 1'b1, t ? 32'h00 : 32'hff, 1'b0);
            cmd(BIT_TO_TRANSFER_OP, 5'd7, t ? 3'd4 : 3'd3, 5'd0, 1'b1);
            rd("transfer flag", ST, 32'(fl));
            cmd(TRANSFER_TO_BIT_OP, 5'd8, 3'd2, 5'd0, 1'b1);
            rd("loaded bit", RF + 8'h20, t ? 32'h04 : 32'hfb);
            rd("kept flags", ST, 32'(fl));
        end
        $display("test transfer done");
        xfer(ST, 1'b1, 32'ha5, 1'b0);
        xfer(SP_ADDR, 1'b1, 32'h00fe, 1'b0);
        cmd(POP_OP, 5'd9, 3'd0, 5'd0, 1'b0);
        // Lands in the second execution cycle, so it must be refused
        xfer(RF + 8'h28, 1'b1, 32'h77, 1'b1);
        settle();
        rd("popped", RF + 8'h24, 32'ha3);
        rd("stack ptr", SP_ADDR, 32'h00ff);
        rd("refused", RF + 8'h28, 32'h0);
        rd("pop flags", ST, 32'ha5);
        $display("test pop done");
        cmd(IO_BIT_SET_OP, 5'd0, 3'd1, 5'd5, 1'b1);
        chk("io set polls", 32'h2, 32'(np));
        chk("io set", 32'h3b, 32'(mem_u.io[5]));
        cmd(IO_BIT_CLEAR_OP, 5'd0, 3'd5, 5'd31, 1'b1);
        chk("io clear polls", 32'h2, 32'(np));
        chk("io clear", 32'h03, 32'(mem_u.io[31]));
        rd("io flags", ST, 32'ha5);
        $display("test io done");
        cmd(SLEEP_OP, 5'd0, 3'd0, 5'd0, 1'b1);
        chk("sleep polls", 32'h1, 32'(np));
        cmd(WATCHDOG_RESTART_OP, 5'd0, 3'd0, 5'd0, 1'b1);
        chk("restart polls", 32'h1, 32'(np));
        cmd(BREAK_OP, 5'd0, 3'd0, 5'd0, 1'b1);
        cmd(IDLE_OP, 5'd0, 3'd0, 5'd0, 1'b1);
        chk("idle polls", 32'h1, 32'(np));
        cmd(6'h1f, 5'd0, 3'd0, 5'd0, 1'b1);
        chk("sleep pulses", 32'h1, 32'(n_slp));
        chk("restart pulses", 32'h1, 32'(n_wdt));
        chk("break pulses", 32'h1, 32'(n_brk));
        rd("control flags", ST, 32'ha5);
        $display("test control done");
        complete_run();
    end
endmodule : tb
